// ### shared/asasc_pkg.sv
// package for the per-axis status and stop-cause block
// assumes a single clock domain and plain-port access, no bus
package asasc_pkg;
    // ==========================================================
    // axes and widths
    localparam int          ASASC_AXES       = 4;
    localparam int          ASASC_AXIS_W     = 2;
    localparam int          ASASC_ACC_W      = 32;
    localparam int          ASASC_SEL_W      = 4;
    localparam int          ASASC_CAUSE_W    = 16;
    // ==========================================================
    // input-state selector codes
    localparam logic [3:0]  SEL_DRIVING      = 4'h0;
    localparam logic [3:0]  SEL_LIMIT_FWD    = 4'h1;
    localparam logic [3:0]  SEL_LIMIT_REV    = 4'h2;
    localparam logic [3:0]  SEL_ESTOP        = 4'h3;
    localparam logic [3:0]  SEL_ALARM        = 4'h4;
    localparam logic [3:0]  SEL_ORIGIN       = 4'h5;
    localparam logic [3:0]  SEL_NEAR_ORIGIN  = 4'h6;
    localparam logic [3:0]  SEL_GEN_IN3      = 4'h7;
    localparam logic [3:0]  SEL_SETTLED      = 4'h8;
    // ==========================================================
    // stop-cause bit positions (weight = 1 << position)
    localparam int          CB_SOFT_FWD      = 0;
    localparam int          CB_SOFT_REV      = 1;
    localparam int          CB_HARD_FWD      = 2;
    localparam int          CB_HARD_REV      = 3;
    localparam int          CB_ALARM         = 4;
    localparam int          CB_ESTOP         = 5;
    localparam int          CB_RESERVED      = 6;
    localparam int          CB_HOME          = 7;
    localparam int          CB_SW_STOP       = 8;
    localparam logic [15:0] CAUSE_RESET      = 16'h0000;
    localparam logic [15:0] CAUSE_USED_MASK  = 16'h01BF;
    localparam logic [31:0] ACC_RESET        = 32'h0000_0000;
endpackage : asasc_pkg

// ### design/asasc_axis_cause.sv
// one axis of sticky stop-cause capture
// assumes inputs synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module asasc_axis_cause
    import asasc_pkg::*;
(
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rst_in,
    // cause conditions
    input  wire logic                     soft_fwd_in,
    input  wire logic                     soft_rev_in,
    input  wire logic                     hard_fwd_in,
    input  wire logic                     hard_rev_in,
    input  wire logic                     alarm_in,
    input  wire logic                     estop_in,
    input  wire logic                     index_in,
    input  wire logic                     origin_in,
    input  wire logic                     sw_stop_in,
    // clear
    input  wire logic                     clear_in,
    // sticky word
    output logic [ASASC_CAUSE_W-1:0]      cause_out
);
    // ==========================================================
    // raw event vector
    logic [ASASC_CAUSE_W-1:0] raw;
    logic [ASASC_CAUSE_W-1:0] cause_q;
    logic [ASASC_CAUSE_W-1:0] cause_d;

    always_comb begin
        raw = CAUSE_RESET;
        raw[CB_SOFT_FWD] = soft_fwd_in;
        raw[CB_SOFT_REV] = soft_rev_in;
        raw[CB_HARD_FWD] = hard_fwd_in;
        raw[CB_HARD_REV] = hard_rev_in;
        raw[CB_ALARM]    = alarm_in;
        raw[CB_ESTOP]    = estop_in;
        raw[CB_HOME]     = index_in & origin_in;
        raw[CB_SW_STOP]  = sw_stop_in;
    end

    // set wins over clear so a same-cycle event is kept
    assign cause_d = ((clear_in ? CAUSE_RESET : cause_q) | raw) & CAUSE_USED_MASK;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cause_q <= CAUSE_RESET;
        end else begin
            cause_q <= cause_d;
        end
    end

    assign cause_out = cause_q;

    // ==========================================================
    // checks
    a_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        cause_q[CB_RESERVED] == 1'b0) else $error("reserved weight set");
    a_cause_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
        ($past(cause_q[CB_ALARM]) && !$past(clear_in)) |-> cause_q[CB_ALARM])
        else $error("alarm cause dropped without clear");
    a_home_pair: assert property (@(posedge clk_in) disable iff (rst_in)
        (index_in && origin_in) |=> cause_q[CB_HOME])
        else $error("home cause missed");
    a_home_single: assert property (@(posedge clk_in) disable iff (rst_in)
        (clear_in && !(index_in && origin_in)) |=> !cause_q[CB_HOME])
        else $error("home cause without both inputs");
endmodule : asasc_axis_cause
`default_nettype wire

// ### design/asasc_top.sv
// per-axis status and stop-cause reporting for four axes
// assumes inputs synchronous to clk_in; host reads through plain ports
// Notes on behaviour
// - four axes; each query answers for the one selected axis, the error flag for all axes
// - present acceleration of the selected axis is readable
// - selector 0 reports whether the axis is outputting pulses
// - selectors 1 and 2 report forward and reverse hardware limits
// - selector 3 reports emergency stop, selector 4 servo alarm
// - selectors 5 to 8: origin, near origin, input three, settled
// - cause word zero when clear, else sum of weights; 64 never set
// - weight 1 on forward software limit
// - weight 2 on reverse software limit
// - weight 4 on forward hardware limit
// - weight 8 on reverse hardware limit
// - weight 16 while servo alarm active
// - weight 32 while emergency stop active
// - weight 128 only when index and origin coincide
// - weight 256 marks a software stop; like any other weight it sets the module-wide error flag
// - module-wide flag set when any axis cause word is non-zero
`timescale 1ns/1ps
`default_nettype none
module asasc_top
    import asasc_pkg::*;
#(
    parameter int AXES = ASASC_AXES
)
(
    // clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    // per-axis live state
    input  wire logic [AXES-1:0]           driving_in,
    input  wire logic [AXES-1:0]           limit_fwd_in,
    input  wire logic [AXES-1:0]           limit_rev_in,
    input  wire logic [AXES-1:0]           alarm_in,
    input  wire logic [AXES-1:0]           origin_in,
    input  wire logic [AXES-1:0]           near_origin_sensor_in,
    input  wire logic [AXES-1:0]           general_input_three_in,
    input  wire logic [AXES-1:0]           servo_settled_input_in,
    input  wire logic [AXES-1:0]           index_in,
    input  wire logic [AXES-1:0]           soft_limit_fwd_in,
    input  wire logic [AXES-1:0]           soft_limit_rev_in,
    input  wire logic [AXES-1:0]           sw_stop_in,
    input  wire logic                      emergency_stop_input_in,
    input  wire logic [AXES*ASASC_ACC_W-1:0] accel_in,
    // host query
    input  wire logic [ASASC_AXIS_W-1:0]   axis_sel_in,
    input  wire logic [ASASC_SEL_W-1:0]    input_sel_in,
    input  wire logic                      clear_stop_condition_in,
    // host answers
    output logic [ASASC_ACC_W-1:0]         present_accel_out,
    output logic                           input_state_out,
    output logic [ASASC_CAUSE_W-1:0]       stop_cause_out,
    output logic                           any_error_out
);
    // ==========================================================
    // elaboration check
    if (AXES != ASASC_AXES) begin : g_axes_check
        $error("axis count must match the two-bit axis selector");
    end

    // ==========================================================
    // per-axis cause capture
    logic [ASASC_CAUSE_W-1:0] cause_w [AXES];
    logic [AXES-1:0]          axis_err;

    for (genvar a = 0; a < AXES; a++) begin : g_axis
        asasc_axis_cause u_cause (
            .clk_in      (clk_in),
            .rst_in      (rst_in),
            .soft_fwd_in (soft_limit_fwd_in[a]),
            .soft_rev_in (soft_limit_rev_in[a]),
            .hard_fwd_in (limit_fwd_in[a]),
            .hard_rev_in (limit_rev_in[a]),
            .alarm_in    (alarm_in[a]),
            .estop_in    (emergency_stop_input_in),
            .index_in    (index_in[a]),
            .origin_in   (origin_in[a]),
            .sw_stop_in  (sw_stop_in[a]),
            .clear_in    (clear_stop_condition_in),
            .cause_out   (cause_w[a])
        );
        assign axis_err[a] = |cause_w[a];
    end

    // ==========================================================
    // selection of the addressed axis
    function automatic logic pick_input(
        input logic [ASASC_SEL_W-1:0] sel,
        input logic [8:0]             vec
    );
        logic r;
        r = 1'b0;
        case (sel)
            SEL_DRIVING:     r = vec[0];
            SEL_LIMIT_FWD:   r = vec[1];
            SEL_LIMIT_REV:   r = vec[2];
            SEL_ESTOP:       r = vec[3];
            SEL_ALARM:       r = vec[4];
            SEL_ORIGIN:      r = vec[5];
            SEL_NEAR_ORIGIN: r = vec[6];
            SEL_GEN_IN3:     r = vec[7];
            SEL_SETTLED:     r = vec[8];
            default:         r = 1'b0;
        endcase
        return r;
    endfunction : pick_input

    wire logic [AXES-1:0] ax = AXES'(1) << axis_sel_in;
    wire logic [8:0] in_vec = {
        |(servo_settled_input_in & ax),
        |(general_input_three_in & ax),
        |(near_origin_sensor_in & ax),
        |(origin_in & ax),
        |(alarm_in & ax),
        emergency_stop_input_in,
        |(limit_rev_in & ax),
        |(limit_fwd_in & ax),
        |(driving_in & ax)
    };
    wire logic                     state_d = pick_input(input_sel_in, in_vec);
    wire logic [ASASC_ACC_W-1:0]   accel_d = accel_in[axis_sel_in*ASASC_ACC_W +: ASASC_ACC_W];
    wire logic [ASASC_CAUSE_W-1:0] cause_d = cause_w[axis_sel_in];

    // ==========================================================
    // answer registers
    logic [ASASC_ACC_W-1:0]   accel_q;
    logic                     state_q;
    logic [ASASC_CAUSE_W-1:0] cause_q;
    logic                     err_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            accel_q <= ACC_RESET;
            state_q <= 1'b0;
            cause_q <= CAUSE_RESET;
            err_q   <= 1'b0;
        end else begin
            accel_q <= accel_d;
            state_q <= state_d;
            cause_q <= cause_d;
            err_q   <= |axis_err;
        end
    end

    // host clears only after removing the cause; a live cause re-sets at once
    assign present_accel_out = accel_q;
    assign input_state_out   = state_q;
    assign stop_cause_out    = cause_q;
    assign any_error_out     = err_q;

    // ==========================================================
    // checks
    a_state_follows: assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=> input_state_out == $past(state_d))
        else $error("input state answer stale");
    a_drive_report: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in == SEL_DRIVING && driving_in[axis_sel_in]) |=> input_state_out)
        else $error("driving not reported");
    a_limit_fwd: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in == SEL_LIMIT_FWD) |=> input_state_out == $past(limit_fwd_in[axis_sel_in]))
        else $error("forward limit misreported");
    a_estop_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in == SEL_ESTOP) |=> input_state_out == $past(emergency_stop_input_in))
        else $error("estop misreported");
    a_settled_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in == SEL_SETTLED) |=>
        input_state_out == $past(servo_settled_input_in[axis_sel_in]))
        else $error("settled misreported");
    a_accel_path: assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=> present_accel_out == $past(accel_d))
        else $error("acceleration misreported");
    a_estop_weight: assert property (@(posedge clk_in) disable iff (rst_in)
        emergency_stop_input_in |=> ##1 stop_cause_out[CB_ESTOP])
        else $error("estop weight missing");
    // answer shows the axis selected one edge after the event, so that pair must agree
    a_alarm_weight: assert property (@(posedge clk_in) disable iff (rst_in)
        alarm_in[axis_sel_in] |=> ##1
        (stop_cause_out[CB_ALARM] || $past(axis_sel_in, 2) != $past(axis_sel_in)))
        else $error("alarm weight missing");
    a_error_flag: assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=> any_error_out == ($past(axis_err) != '0))
        else $error("error flag wrong");
    a_swstop_weight: assert property (@(posedge clk_in) disable iff (rst_in)
        sw_stop_in[0] |=> cause_w[0][CB_SW_STOP])
        else $error("software stop weight missing");
    a_soft_fwd: assert property (@(posedge clk_in) disable iff (rst_in)
        soft_limit_fwd_in[0] |=> cause_w[0][CB_SOFT_FWD])
        else $error("soft forward weight missing");
    a_soft_rev: assert property (@(posedge clk_in) disable iff (rst_in)
        soft_limit_rev_in[0] |=> cause_w[0][CB_SOFT_REV])
        else $error("soft reverse weight missing");
    a_hard_fwd: assert property (@(posedge clk_in) disable iff (rst_in)
        limit_fwd_in[0] |=> cause_w[0][CB_HARD_FWD])
        else $error("hard forward weight missing");
    a_hard_rev: assert property (@(posedge clk_in) disable iff (rst_in)
        limit_rev_in[0] |=> cause_w[0][CB_HARD_REV])
        else $error("hard reverse weight missing");
    a_limit_rev: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in == SEL_LIMIT_REV) |=> input_state_out == $past(limit_rev_in[axis_sel_in]))
        else $error("reverse limit misreported");
    a_alarm_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in == SEL_ALARM) |=> input_state_out == $past(alarm_in[axis_sel_in]))
        else $error("alarm misreported");
    a_origin_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in == SEL_ORIGIN) |=> input_state_out == $past(origin_in[axis_sel_in]))
        else $error("origin misreported");
    a_near_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in == SEL_NEAR_ORIGIN) |=>
        input_state_out == $past(near_origin_sensor_in[axis_sel_in]))
        else $error("near origin misreported");
    a_gen3_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in == SEL_GEN_IN3) |=>
        input_state_out == $past(general_input_three_in[axis_sel_in]))
        else $error("input three misreported");
    a_drive_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in == SEL_DRIVING && !driving_in[axis_sel_in]) |=> !input_state_out)
        else $error("idle axis reported driving");
    a_unused_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        (input_sel_in > SEL_SETTLED) |=> !input_state_out)
        else $error("unsupported selector not zero");

    // ==========================================================
    // answer paths; the cause answer lags the capture by one edge
    a_cause_path: assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=> stop_cause_out == $past(cause_w[axis_sel_in]))
        else $error("cause word of wrong axis");
    a_unused_bits: assert property (@(posedge clk_in) disable iff (rst_in)
        (stop_cause_out & ~CAUSE_USED_MASK) == CAUSE_RESET)
        else $error("unused cause bit set");
    a_accel_pick: assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=>
        present_accel_out == $past(accel_in[axis_sel_in*ASASC_ACC_W +: ASASC_ACC_W]))
        else $error("acceleration of wrong axis");
    a_home_weight: assert property (@(posedge clk_in) disable iff (rst_in)
        (index_in[axis_sel_in] && origin_in[axis_sel_in]) |=> ##1
        (stop_cause_out[CB_HOME] || $past(axis_sel_in, 2) != $past(axis_sel_in)))
        else $error("home weight not answered");
    a_swstop_out: assert property (@(posedge clk_in) disable iff (rst_in)
        sw_stop_in[axis_sel_in] |=> ##1
        (stop_cause_out[CB_SW_STOP] || $past(axis_sel_in, 2) != $past(axis_sel_in)))
        else $error("software stop weight not answered");

    // ==========================================================
    // every axis: each weight set by its own cause and by nothing else
    for (genvar c = 0; c < AXES; c++) begin : g_axis_chk
        a_soft_fwd_ax: assert property (@(posedge clk_in) disable iff (rst_in)
            soft_limit_fwd_in[c] |=> cause_w[c][CB_SOFT_FWD])
            else $error("soft forward weight missing");
        a_soft_rev_ax: assert property (@(posedge clk_in) disable iff (rst_in)
            soft_limit_rev_in[c] |=> cause_w[c][CB_SOFT_REV])
            else $error("soft reverse weight missing");
        a_hard_fwd_ax: assert property (@(posedge clk_in) disable iff (rst_in)
            limit_fwd_in[c] |=> cause_w[c][CB_HARD_FWD])
            else $error("hard forward weight missing");
        a_hard_rev_ax: assert property (@(posedge clk_in) disable iff (rst_in)
            limit_rev_in[c] |=> cause_w[c][CB_HARD_REV])
            else $error("hard reverse weight missing");
        a_alarm_ax: assert property (@(posedge clk_in) disable iff (rst_in)
            alarm_in[c] |=> cause_w[c][CB_ALARM])
            else $error("alarm weight missing");
        a_estop_ax: assert property (@(posedge clk_in) disable iff (rst_in)
            emergency_stop_input_in |=> cause_w[c][CB_ESTOP])
            else $error("estop weight missing");
        a_home_ax: assert property (@(posedge clk_in) disable iff (rst_in)
            (index_in[c] && origin_in[c]) |=> cause_w[c][CB_HOME])
            else $error("home weight missing");
        a_swstop_ax: assert property (@(posedge clk_in) disable iff (rst_in)
            sw_stop_in[c] |=> cause_w[c][CB_SW_STOP])
            else $error("software stop weight missing");
        a_soft_fwd_only: assert property (@(posedge clk_in) disable iff (rst_in)
            $rose(cause_w[c][CB_SOFT_FWD]) |-> $past(soft_limit_fwd_in[c]))
            else $error("soft forward weight without cause");
        a_soft_rev_only: assert property (@(posedge clk_in) disable iff (rst_in)
            $rose(cause_w[c][CB_SOFT_REV]) |-> $past(soft_limit_rev_in[c]))
            else $error("soft reverse weight without cause");
        a_hard_fwd_only: assert property (@(posedge clk_in) disable iff (rst_in)
            $rose(cause_w[c][CB_HARD_FWD]) |-> $past(limit_fwd_in[c]))
            else $error("hard forward weight without cause");
        a_hard_rev_only: assert property (@(posedge clk_in) disable iff (rst_in)
            $rose(cause_w[c][CB_HARD_REV]) |-> $past(limit_rev_in[c]))
            else $error("hard reverse weight without cause");
        a_alarm_only: assert property (@(posedge clk_in) disable iff (rst_in)
            $rose(cause_w[c][CB_ALARM]) |-> $past(alarm_in[c]))
            else $error("alarm weight without cause");
        a_estop_only: assert property (@(posedge clk_in) disable iff (rst_in)
            $rose(cause_w[c][CB_ESTOP]) |-> $past(emergency_stop_input_in))
            else $error("estop weight without cause");
        a_home_only: assert property (@(posedge clk_in) disable iff (rst_in)
            $rose(cause_w[c][CB_HOME]) |-> $past(index_in[c] && origin_in[c]))
            else $error("home weight without both inputs");
        a_swstop_only: assert property (@(posedge clk_in) disable iff (rst_in)
            $rose(cause_w[c][CB_SW_STOP]) |-> $past(sw_stop_in[c]))
            else $error("software stop weight without cause");
        a_clear_ax: assert property (@(posedge clk_in) disable iff (rst_in)
            (clear_stop_condition_in && !emergency_stop_input_in && !alarm_in[c]
             && !sw_stop_in[c] && !limit_fwd_in[c] && !limit_rev_in[c] && !index_in[c]
             && !soft_limit_fwd_in[c] && !soft_limit_rev_in[c]) |=> cause_w[c] == CAUSE_RESET)
            else $error("clear left a cause set");
        a_hold_ax: assert property (@(posedge clk_in) disable iff (rst_in)
            !clear_stop_condition_in |=> (cause_w[c] | $past(cause_w[c])) == cause_w[c])
            else $error("cause bit dropped without clear");
    end
endmodule : asasc_top
`default_nettype wire

// ### tb/asasc_host_model.sv
// host-side model: axis query and clear-stop requests
// assumes drive is called just after a rising edge of the bench clock
`timescale 1ns/1ps
`default_nettype none
module asasc_host_model
    import asasc_pkg::*;
(
    // host query
    output logic [ASASC_AXIS_W-1:0] axis_sel_out,
    output logic [ASASC_SEL_W-1:0]  input_sel_out,
    output logic                    clear_out
);
    // ==========================================================
    // request drive
    initial begin
        axis_sel_out  = 2'h0;
        input_sel_out = 4'h0;
        clear_out     = 1'b0;
    end
    // the directed steps remove causes first; a random clear over a live cause is a refusal test
    task automatic drive(input logic [1:0] a, input logic [3:0] s, input logic c);
        axis_sel_out  <= a;
        input_sel_out <= s;
        clear_out     <= c;
    endtask : drive
endmodule : asasc_host_model
`default_nettype wire

// ### tb/tb_asasc_top.sv
// self-checking bench for the status and stop-cause block
// assumes the design package and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_asasc_top;
    import asasc_pkg::*;
    // ==========================================================
    // signals
    typedef struct {logic [31:0] acc; logic st; logic [15:0] cause; logic any;} asasc_note_t;
    logic           clk_in = 1'b0;
    logic           rst_in = 1'b1;
    logic           estop  = 1'b0;
    logic           estop_nx;
    logic [3:0]     lv [12];
    logic [3:0]     nx [12];
    logic [127:0]   acc    = 128'h0;
    logic [127:0]   acc_nx;
    logic [15:0]    sticky [4];
    wire  [1:0]     axis_sel;
    wire  [3:0]     input_sel;
    wire            clr;
    wire  [31:0]    acc_o;
    wire            st_o;
    wire  [15:0]    cause_o;
    wire            any_o;
    asasc_note_t    notes [$];
    asasc_note_t    mon_n;
    int             err_count  = 0;
    int             num_checks = 0;
    int             seed       = 32'h2409D421;
    initial foreach (lv[i]) lv[i] = 4'h0;
    initial forever #50 clk_in = ~clk_in;
    // ==========================================================
    // design and host
    asasc_host_model host_u (.axis_sel_out(axis_sel), .input_sel_out(input_sel),
                             .clear_out(clr));
    asasc_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .driving_in(lv[0]),
        .limit_fwd_in(lv[1]), .limit_rev_in(lv[2]), .alarm_in(lv[3]), .origin_in(lv[4]),
        .near_origin_sensor_in(lv[5]), .general_input_three_in(lv[6]),
        .servo_settled_input_in(lv[7]), .index_in(lv[8]), .soft_limit_fwd_in(lv[9]),
        .soft_limit_rev_in(lv[10]), .sw_stop_in(lv[11]), .emergency_stop_input_in(estop),
        .accel_in(acc), .axis_sel_in(axis_sel), .input_sel_in(input_sel),
        .clear_stop_condition_in(clr), .present_accel_out(acc_o),
        .input_state_out(st_o), .stop_cause_out(cause_o), .any_error_out(any_o));
    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [15:0] cw(input int k);
        cw = {7'h00, nx[11][k], nx[8][k] & nx[4][k], 1'b0, estop_nx, nx[3][k], nx[2][k],
              nx[1][k], nx[10][k], nx[9][k]};
    endfunction : cw
    // drive one query, hold it three edges, note what the outputs must show
    task automatic apply(input logic [1:0] a, input logic [3:0] s, input logic c);
        asasc_note_t n;
        logic [8:0]  v;
        @(posedge clk_in);
        foreach (lv[i]) lv[i] <= nx[i];
        estop <= estop_nx;
        acc   <= acc_nx;
        host_u.drive(a, s, c);
        repeat (3) @(posedge clk_in);
        for (int k = 0; k < 4; k++) sticky[k] = c ? cw(k) : (sticky[k] | cw(k));
        v = {nx[7][a], nx[6][a], nx[5][a], nx[4][a], nx[3][a], estop_nx, nx[2][a],
             nx[1][a], nx[0][a]};
        n.acc   = acc_nx[a*32 +: 32];
        n.st    = (s < 9) ? v[s] : 1'b0;
        n.cause = sticky[a];
        n.any   = |(sticky[0] | sticky[1] | sticky[2] | sticky[3]);
        notes.push_back(n);
    endtask : apply
    task automatic clean;
        foreach (nx[i]) nx[i] = 4'h0;
        estop_nx = 1'b0;
        acc_nx   = 128'h0;
    endtask : clean
    task automatic finish_test;
        $display("errors %0d checks %0d", err_count, num_checks);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    // ==========================================================
    // monitor: oldest note against the settled outputs
    always @(negedge clk_in) begin
        while (notes.size() > 0) begin
            mon_n = notes.pop_front();
            chk(acc_o, mon_n.acc);
            chk({31'h0, st_o}, {31'h0, mon_n.st});
            chk({16'h0, cause_o}, {16'h0, mon_n.cause});
            chk({31'h0, any_o}, {31'h0, mon_n.any});
        end
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        finish_test;
    end
    // ==========================================================
    // main sequence
    initial begin
        foreach (sticky[k]) sticky[k] = 16'h0000;
        clean;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        apply(2'h0, 4'h0, 1'b0);
        // every axis and selector, live inputs random, clear sometimes over live causes
        for (int a = 0; a < 4; a++) begin
            for (int s = 0; s < 10; s++) begin
                foreach (nx[i]) nx[i] = 4'($random(seed));
                estop_nx = 1'($random(seed));
                acc_nx   = {$random(seed), $random(seed), $random(seed), $random(seed)};
                apply(2'(a), 4'(s), 1'($random(seed)));
            end
        end
        clean;
        apply(2'h1, 4'h0, 1'b1);
        // single and paired causes: weight, stickiness, clear
        for (int j = 0; j < 11; j++) begin
            clean;
            case (j)
                0: nx[9][j%4] = 1'b1;
                1: nx[10][j%4] = 1'b1;
                2: nx[1][j%4] = 1'b1;
                3: nx[2][j%4] = 1'b1;
                4: nx[3][j%4] = 1'b1;
                5: estop_nx = 1'b1;
                6: begin nx[8][j%4] = 1'b1; nx[4][j%4] = 1'b1; end
                7: nx[11][j%4] = 1'b1;
                8: nx[8][j%4] = 1'b1;
                9: nx[4][j%4] = 1'b1;
                default: begin nx[3][j%4] = 1'b1; estop_nx = 1'b1; end
            endcase
            apply(2'(j % 4), 4'h4, 1'b0);
            clean;
            apply(2'(j % 4), 4'h3, 1'b0);
            apply(2'((j + 1) % 4), 4'h0, 1'b0);
            apply(2'(j % 4), 4'h0, 1'b1);
        end
        repeat (2) @(posedge clk_in);
        finish_test;
    end
endmodule : tb_asasc_top
`default_nettype wire
